// >>> hsfs_ctrl.sv
// Fault shutdown control of four high-side switches: control register,
// fault input synchronisers and per-switch shutdown demands.
// Assumes the serial port decodes its own frames and gives one write strobe
// per register access; fault flags come from analog comparators.
// Mode flags and control selections come from logic on mclk and are used
// directly; only the comparator flags cross in from outside the clock.
// Summary of operation
// - Bits 15..12 choose per-switch overvoltage recovery
// - Bit 11: overtemperature shuts all or only the switches at fault
// - Bits 10..7 disable normal-mode overvoltage shutdown
// - Bit 6 disables stop/sleep overvoltage shutdown
// - Bit 5 disables undervoltage shutdown
// - Bit 3 enables undervoltage recovery
// - Reserved bits 4, 2..0 read zero
// - Power-on or soft reset clears register
// - Restart reset keeps writable bits
// - Recovery restores the switch's control selection
`timescale 1ns/1ps
module hsfs_ctrl #(
    parameter int NSW = 4                              // Number of switches
) (
    input  wire logic                     mclk,         // 100 MHz clock
    input  wire logic                     nrst,         // Power-on reset, active low
    input  wire logic                     soft_rst,     // Soft reset pulse
    input  wire logic                     restart_rst,  // Restart reset pulse
    input  wire logic                     reg_wr,       // Write strobe, one cycle
    input  wire logic [6:0]               reg_addr,     // Register offset
    input  wire logic [15:0]              reg_wdata,    // Write data
    output      logic [15:0]              reg_rdata,    // Read data
    input  wire logic                     normal_mode,  // Device in normal mode
    input  wire logic                     lowpower_mode,// Device in stop or sleep
    input  wire logic                     supply_ov,    // Supply overvoltage flag
    input  wire logic                     supply_uv,    // Supply undervoltage flag
    input  wire logic [NSW-1:0]           overtemp,     // Per-switch overtemperature
    input  wire logic [4*NSW-1:0]         ctl_sel,      // Control selections
    input  wire logic [NSW-1:0]           sel_wr,       // Selection rewritten pulses
    output      logic [4*NSW-1:0]         eff_sel       // Applied selections
);
    import hsfs_pkg::*;

    localparam int NF = NSW + 2;            // Synchronised fault inputs

    logic [15:0]    ctrl_q;                 // The control register
    logic [NF-1:0]  raw_f;                  // Fault pins, gathered
    logic [NF-1:0]  sync1_q;                // First synchroniser stage
    logic [NF-1:0]  sync2_q;                // Second stage
    logic [NF-1:0]  sync3_q;                // Third stage
    logic [NF-1:0]  filt_q;                 // Confirmed fault levels
    logic           ov_f;                   // Confirmed overvoltage
    logic           uv_f;                   // Confirmed undervoltage
    logic [NSW-1:0] ot_f;                   // Confirmed overtemperature
    logic [NSW-1:0] ov_req;                 // Overvoltage demands
    logic           uv_req;                 // Undervoltage demand
    logic [NSW-1:0] ot_req;                 // Overtemperature demands
    logic           hit;                    // Access selects this register

    // Field extraction used more than once
    function automatic logic fbit(input logic [15:0] r, input int pos);
        fbit = r[pos];
    endfunction : fbit

    // Register select; the offset arrives with each serial frame
    assign hit = (reg_addr == HSFS_REG_OFS);

    // Control register; soft reset beats a same-cycle write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= HSFS_RST_VAL;
        end else if (soft_rst) begin
            ctrl_q <= HSFS_RST_VAL;
        end else if (restart_rst) begin
            ctrl_q <= ctrl_q & HSFS_RESTART_KEEP;
        end else if (reg_wr && hit) begin
            ctrl_q <= reg_wdata & HSFS_WR_MASK;
        end
    end

    // Read path comes straight from the register flops
    always_comb begin
        if (hit) reg_rdata = ctrl_q;
        else reg_rdata = 16'h0000;
    end

    // Three-stage synchroniser; level taken only when stages 2 and 3 agree
    assign raw_f = {overtemp, supply_uv, supply_ov};
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= raw_f;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Confirmed level per input; a single-cycle glitch is not taken
    // Costs one more cycle of latency, traded for immunity to comparator
    // chatter near the threshold
    generate
        for (genvar g = 0; g < NF; g++) begin : g_filt
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) filt_q[g] <= 1'b0;
                else if (sync2_q[g] == sync3_q[g]) filt_q[g] <= sync3_q[g];
            end
        end
    endgenerate

    // Gathered order: overvoltage, undervoltage, then one per switch
    assign ov_f = filt_q[0];
    assign uv_f = filt_q[1];
    assign ot_f = filt_q[NF-1:2];

    // Mode flags are on mclk already, so they skip the synchroniser
    // Shutdown demands from faults, mode and configuration
    always_comb begin
        for (int i = 0; i < NSW; i++) begin
            ov_req[i] = ov_f && ((normal_mode && !fbit(ctrl_q, HSFS_OV_SDN_LSB + i))
                       || (lowpower_mode && !fbit(ctrl_q, HSFS_LP_OV_BIT)));
            ot_req[i] = fbit(ctrl_q, HSFS_OT_INDIV_BIT) ? ot_f[i] : |ot_f;
        end
        uv_req = uv_f && !fbit(ctrl_q, HSFS_UV_SD_BIT);
    end

    // One state keeper per switch
    // Each keeper remembers which faults took its switch off
    generate
        for (genvar s = 0; s < NSW; s++) begin : g_sw
            hsfs_sw_if sw_if ();
            assign sw_if.ov_req  = ov_req[s];
            assign sw_if.uv_req  = uv_req;
            assign sw_if.ot_req  = ot_req[s];
            assign sw_if.ov_rec  = fbit(ctrl_q, HSFS_OV_REC_LSB + s);
            assign sw_if.uv_rec  = fbit(ctrl_q, HSFS_UV_REC_BIT);
            assign sw_if.ctl_sel = ctl_sel[4*s +: 4];
            assign sw_if.sel_wr  = sel_wr[s];
            assign eff_sel[4*s +: 4] = sw_if.eff_sel;
            hsfs_switch u_sw (
                .mclk (mclk),
                .nrst (nrst),
                .sw   (sw_if)
            );
        end
    endgenerate

    // Reserved bits always read zero
    rsv_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q[4] == 1'b0 && ctrl_q[2:0] == 3'h0) else $error("reserved bit set");
    // Soft reset clears the whole register
    soft_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
        soft_rst |=> ctrl_q == 16'h0000) else $error("soft reset did not clear");
    // Restart leaves register alone
    restart_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
        restart_rst && !soft_rst |=> ctrl_q == $past(ctrl_q)) else $error("restart changed bits");
    // Write lands masked one cycle on
    write_take_a: assert property (@(posedge mclk) disable iff (!nrst)
        reg_wr && hit && !soft_rst && !restart_rst |=> ctrl_q == ($past(reg_wdata) & 16'hffe8))
        else $error("write not stored");
    // Shared overtemperature shuts every switch
    ot_all_a: assert property (@(posedge mclk) disable iff (!nrst)
        |ot_f && !ctrl_q[11] |-> &ot_req) else $error("ot not shared");
    // Individual overtemperature shuts only the switches at fault
    ot_indiv_a: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q[11] |-> ot_req == ot_f) else $error("ot not individual");
    // Normal-mode ov disable keeps its switch running
    ov_norm_a: assert property (@(posedge mclk) disable iff (!nrst)
        normal_mode && !lowpower_mode && ov_f |-> ov_req == ~ctrl_q[HSFS_OV_SDN_LSB +: NSW])
        else $error("normal ov shutdown wrong");
    // Low-power ov disable
    ov_lp_a: assert property (@(posedge mclk) disable iff (!nrst)
        lowpower_mode && !normal_mode && ov_f |-> ov_req == {NSW{!ctrl_q[6]}})
        else $error("low-power ov shutdown wrong");
    // Undervoltage disable
    uv_sd_a: assert property (@(posedge mclk) disable iff (!nrst)
        uv_f |-> uv_req == !ctrl_q[5]) else $error("uv shutdown wrong");

    // Reserved bits read back as zero
    rd_rsv_a: assert property (@(posedge mclk) disable iff (!nrst)
        hit |-> reg_rdata[4] == 1'b0 && reg_rdata[2:0] == 3'h0)
        else $error("reserved bit read");
    // No overvoltage shutdown outside normal, stop and sleep
    ov_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
        !normal_mode && !lowpower_mode |-> ov_req == '0)
        else $error("ov shutdown without mode");
    // Overvoltage shutdown only while the fault stands
    ov_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        !ov_f |-> ov_req == '0)
        else $error("ov shutdown without fault");
    // Overtemperature shutdown only while a fault stands
    ot_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        !(|ot_f) |-> ot_req == '0)
        else $error("ot shutdown without fault");
    // Undervoltage shutdown only while the fault stands
    uv_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        !uv_f |-> !uv_req)
        else $error("uv shutdown without fault");

    // Confirmed level holds while stages two and three disagree
    filt_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        ((filt_q ^ $past(filt_q)) & $past(sync2_q ^ sync3_q)) == {NF{1'b0}})
        else $error("fault filter took a glitch");
    // Confirmed level follows stage three once the stages agree
    filt_take_a: assert property (@(posedge mclk) disable iff (!nrst)
        ((filt_q ^ $past(sync3_q)) & ~$past(sync2_q ^ sync3_q)) == {NF{1'b0}})
        else $error("fault filter missed a level");
    ot_cov: cover property (@(posedge mclk) disable iff (!nrst) |ot_f && ctrl_q[11]);
    ov_cov: cover property (@(posedge mclk) disable iff (!nrst) ov_f && normal_mode);
    uv_cov: cover property (@(posedge mclk) disable iff (!nrst) uv_req ##1 !uv_req);
endmodule : hsfs_ctrl

// >>> hsfs_ctrl_tb.sv
// Self-checking bench for the high-side switch fault shutdown controller.
// Assumes hsfs_pkg and the controller top; all inputs move on the rising edge.
`timescale 1ns/1ps
module hsfs_ctrl_tb;
    import hsfs_pkg::*;
    localparam logic [15:0] SEL = 16'h8721;  // Nonzero selection per switch
    logic        mclk;           // Clock
    logic        nrst;           // Power-on reset
    logic        soft_rst;       // Soft reset pulse
    logic        restart_rst;    // Restart reset pulse
    logic        reg_wr;         // Write strobe
    logic [6:0]  reg_addr;       // Register offset
    logic [15:0] reg_wdata;      // Write data
    logic [15:0] reg_rdata;      // Read data
    logic        normal_mode;    // Normal mode
    logic        lowpower_mode;  // Stop or sleep mode
    logic        supply_ov;      // Supply overvoltage
    logic        supply_uv;      // Supply undervoltage
    logic [3:0]  overtemp;       // Per-switch overtemperature
    logic [15:0] ctl_sel;        // Control selections
    logic [3:0]  sel_wr;         // Selection rewrite pulses
    logic [15:0] eff_sel;        // Applied selections
    int          fail_count = 0; // Mismatches seen
    int          checked = 0;    // Comparisons made
    int          cycles = 0;     // Hang guard

    hsfs_ctrl #(.NSW(4)) hsfs_ctrl_inst (
        .mclk(mclk), .nrst(nrst), .soft_rst(soft_rst), .restart_rst(restart_rst),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .normal_mode(normal_mode),
        .lowpower_mode(lowpower_mode), .supply_ov(supply_ov), .supply_uv(supply_uv),
        .overtemp(overtemp), .ctl_sel(ctl_sel), .sel_wr(sel_wr), .eff_sel(eff_sel)
    );

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // One comparison of a 16-bit result
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Single write; address left on the bus so the read mux can be seen
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // Set fault levels, then allow the synchroniser and state update to settle
    task automatic fault(input logic ov, input logic uv, input logic [3:0] ot);
        @(posedge mclk);
        supply_ov <= ov;
        supply_uv <= uv;
        overtemp  <= ot;
        repeat (6) @(posedge mclk);
        #1;
    endtask : fault

    // Software rewrites the selections of the masked switches
    task automatic rewrite(input logic [3:0] m);
        @(posedge mclk);
        sel_wr <= m;
        @(posedge mclk);
        sel_wr <= 4'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : rewrite

    // Reset value, reserved bits, unmapped offset
    task automatic t_regs;
        chk("reg after power-on", HSFS_RST_VAL, reg_rdata);
        chk("sel after power-on", SEL, eff_sel);
        wr(7'h07, 16'hffff);
        chk("reserved bits", 16'hffe8, reg_rdata);
        wr(7'h08, 16'h0000);
        chk("unmapped read", 16'h0000, reg_rdata);
        wr(7'h07, 16'h0017);
        chk("reserved only", 16'h0000, reg_rdata);
    endtask : t_regs

    // Restart keeps writable bits; soft reset clears all
    task automatic t_resets;
        wr(7'h07, 16'h5a5f);
        chk("pattern write", 16'h5a48, reg_rdata);
        @(posedge mclk);
        restart_rst <= 1'b1;
        @(posedge mclk);
        restart_rst <= 1'b0;
        #1;
        chk("after restart", 16'h5a48, reg_rdata);
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
        #1;
        chk("after soft reset", 16'h0000, reg_rdata);
    endtask : t_resets

    // Normal mode: switch1 immune, switch2 recovers, switch3/4 latch off
    task automatic t_normal_ov;
        wr(7'h07, 16'h2080);
        fault(1'b1, 1'b0, 4'h0);
        chk("normal ov on", 16'h0001, eff_sel);
        fault(1'b0, 1'b0, 4'h0);
        chk("normal ov clear", 16'h0021, eff_sel);
        rewrite(4'hc);
        chk("normal ov rewrite", SEL, eff_sel);
    endtask : t_normal_ov

    // Stop or sleep: common disable, then all four recovery bits
    task automatic t_lowpower_ov;
        @(posedge mclk);
        normal_mode   <= 1'b0;
        lowpower_mode <= 1'b1;
        wr(7'h07, 16'hf040);
        fault(1'b1, 1'b0, 4'h0);
        chk("lowpower ov kept", SEL, eff_sel);
        wr(7'h07, 16'hf000);
        fault(1'b1, 1'b0, 4'h0);
        chk("lowpower ov off", 16'h0000, eff_sel);
        fault(1'b0, 1'b0, 4'h0);
        chk("lowpower ov recover", SEL, eff_sel);
        @(posedge mclk);
        lowpower_mode <= 1'b0;
        @(posedge mclk);
        normal_mode   <= 1'b1;
    endtask : t_lowpower_ov

    // Undervoltage: disable, recovery, latch without recovery
    task automatic t_uv;
        wr(7'h07, 16'h0020);
        fault(1'b0, 1'b1, 4'h0);
        chk("uv kept", SEL, eff_sel);
        wr(7'h07, 16'h0008);
        fault(1'b0, 1'b1, 4'h0);
        chk("uv off", 16'h0000, eff_sel);
        fault(1'b0, 1'b0, 4'h0);
        chk("uv recover", SEL, eff_sel);
        wr(7'h07, 16'h0000);
        fault(1'b0, 1'b1, 4'h0);
        fault(1'b0, 1'b0, 4'h0);
        chk("uv latched", 16'h0000, eff_sel);
        rewrite(4'hf);
        chk("uv rewrite", SEL, eff_sel);
    endtask : t_uv

    // Overtemperature on switch2: all off, then only switch2 off
    task automatic t_ot;
        fault(1'b0, 1'b0, 4'h2);
        chk("ot all off", 16'h0000, eff_sel);
        fault(1'b0, 1'b0, 4'h0);
        rewrite(4'hf);
        chk("ot all rewrite", SEL, eff_sel);
        wr(7'h07, 16'h0800);
        fault(1'b0, 1'b0, 4'h2);
        chk("ot individual", 16'h8701, eff_sel);
        fault(1'b0, 1'b0, 4'h0);
        rewrite(4'h2);
        chk("ot individual rewrite", SEL, eff_sel);
    endtask : t_ot

    // Main sequence
    initial begin
        nrst          = 1'b0;
        soft_rst      = 1'b0;
        restart_rst   = 1'b0;
        reg_wr        = 1'b0;
        reg_addr      = HSFS_REG_OFS;
        reg_wdata     = 16'h0000;
        normal_mode   = 1'b1;
        lowpower_mode = 1'b0;
        supply_ov     = 1'b0;
        supply_uv     = 1'b0;
        overtemp      = 4'h0;
        ctl_sel       = SEL;
        sel_wr        = 4'h0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        t_regs();
        t_resets();
        t_normal_ov();
        t_lowpower_ov();
        t_uv();
        t_ot();
        print_verdict();
    end
endmodule : hsfs_ctrl_tb

// >>> hsfs_pkg.sv
// Constants and types for the high-side switch fault shutdown control.
// Assumes one 16-bit control register reached by the serial control port.
package hsfs_pkg;
    // Register offset on the serial control port
    localparam logic [6:0]  HSFS_REG_OFS    = 7'h07;
    // Value after power-on or soft reset
    localparam logic [15:0] HSFS_RST_VAL    = 16'h0000;
    // Writable bits; reserved 4 and 2..0 stay zero
    localparam logic [15:0] HSFS_WR_MASK    = 16'hffe8;
    // Bits kept through a restart reset
    localparam logic [15:0] HSFS_RESTART_KEEP = 16'hffe8;
    // Field positions
    localparam int HSFS_OV_REC_LSB   = 12;  // Per-switch overvoltage recovery
    localparam int HSFS_OT_INDIV_BIT = 11;  // Overtemperature individual shutdown
    localparam int HSFS_OV_SDN_LSB   = 7;   // Per-switch normal-mode ov shutdown off
    localparam int HSFS_LP_OV_BIT    = 6;   // Stop/sleep ov shutdown off
    localparam int HSFS_UV_SD_BIT    = 5;   // Undervoltage shutdown off
    localparam int HSFS_UV_REC_BIT   = 3;   // Undervoltage recovery
    // Selection code for a switch that is off
    localparam logic [3:0]  HSFS_SEL_OFF    = 4'h0;
    // Stages of the fault input synchroniser
    localparam int HSFS_SYNC_STAGES = 3;
    // Per-switch shutdown states, one-hot
    typedef enum logic [2:0] {
        HSFS_ON    = 3'b001,
        HSFS_FAULT = 3'b010,
        HSFS_LATCH = 3'b100
    } hsfs_state_t;
endpackage : hsfs_pkg

// >>> hsfs_sw_if.sv
// Carrier between the shutdown controller and one switch's state keeper.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface hsfs_sw_if;
    logic       ov_req;   // Overvoltage shutdown demanded
    logic       uv_req;   // Undervoltage shutdown demanded
    logic       ot_req;   // Overtemperature shutdown demanded
    logic       ov_rec;   // Recover after overvoltage
    logic       uv_rec;   // Recover after undervoltage
    logic [3:0] ctl_sel;  // Software control selection
    logic       sel_wr;   // Selection rewritten by software
    logic [3:0] eff_sel;  // Selection actually applied
    modport ctrl (output ov_req, uv_req, ot_req, ov_rec, uv_rec, ctl_sel, sel_wr,
                  input eff_sel);
    modport sw   (input ov_req, uv_req, ot_req, ov_rec, uv_rec, ctl_sel, sel_wr,
                  output eff_sel);
endinterface : hsfs_sw_if

// >>> hsfs_switch.sv
// Shutdown and recovery state of one high-side switch.
// Assumes fault demands are already synchronised to mclk.
`timescale 1ns/1ps
module hsfs_switch (
    input wire logic mclk,  // System clock
    input wire logic nrst,  // Async reset, active low
    hsfs_sw_if.sw    sw     // Link to the controller
);
    import hsfs_pkg::*;

    hsfs_state_t state_q;      // Shutdown state
    logic        ov_seen_q;    // Overvoltage took part in this shutdown
    logic        uv_seen_q;    // Undervoltage took part
    logic        ot_seen_q;    // Overtemperature took part
    logic        any_f;        // Any demand active
    logic        recoverable;  // All causes allow recovery

    assign any_f = sw.ov_req | sw.uv_req | sw.ot_req;
    // Overtemperature never recovers by itself; a rewrite is needed
    assign recoverable = !(ov_seen_q && !sw.ov_rec) && !(uv_seen_q && !sw.uv_rec) && !ot_seen_q;

    // Cause memory; a new demand wins over a clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ov_seen_q <= 1'b0;
            uv_seen_q <= 1'b0;
            ot_seen_q <= 1'b0;
        end else if (state_q == HSFS_ON && !any_f) begin
            ov_seen_q <= 1'b0;
            uv_seen_q <= 1'b0;
            ot_seen_q <= 1'b0;
        end else begin
            ov_seen_q <= sw.ov_req | (ov_seen_q & !sw.sel_wr);
            uv_seen_q <= sw.uv_req | (uv_seen_q & !sw.sel_wr);
            ot_seen_q <= sw.ot_req | (ot_seen_q & !sw.sel_wr);
        end
    end

    // State machine
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= HSFS_ON;
        end else begin
            case (state_q)
                HSFS_ON: begin
                    if (any_f) state_q <= HSFS_FAULT;
                end
                HSFS_FAULT: begin
                    if (!any_f) state_q <= recoverable ? HSFS_ON : HSFS_LATCH;
                end
                HSFS_LATCH: begin
                    if (any_f) state_q <= HSFS_FAULT;
                    else if (sw.sel_wr) state_q <= HSFS_ON;
                end
                default: state_q <= HSFS_ON;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) sw.eff_sel <= HSFS_SEL_OFF;
        else if (state_q == HSFS_ON && !any_f) sw.eff_sel <= sw.ctl_sel;
        else sw.eff_sel <= HSFS_SEL_OFF;
    end

    // Demand forces the switch off next cycle
    fault_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        any_f |=> sw.eff_sel == HSFS_SEL_OFF) else $error("switch not off on fault");
    // Latched switch stays off without rewrite
    latch_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == HSFS_LATCH && !any_f && !sw.sel_wr |=> state_q == HSFS_LATCH
        ##1 sw.eff_sel == HSFS_SEL_OFF) else $error("latched switch released");
    // Recovery restores selection two cycles on
    recover_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == HSFS_FAULT && !any_f && recoverable ##1 !any_f
        |=> sw.eff_sel == $past(sw.ctl_sel)) else $error("recovery selection wrong");
    // Non-recoverable ov goes to latch
    ov_norec_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == HSFS_FAULT && !any_f && ov_seen_q && !sw.ov_rec
        |=> state_q == HSFS_LATCH) else $error("ov latch missed");
    // Non-recoverable uv goes to latch
    uv_norec_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == HSFS_FAULT && !any_f && uv_seen_q && !sw.uv_rec
        |=> state_q == HSFS_LATCH) else $error("uv latch missed");
    latch_cov: cover property (@(posedge mclk) disable iff (!nrst)
        state_q == HSFS_LATCH ##1 state_q == HSFS_ON);
    recov_cov: cover property (@(posedge mclk) disable iff (!nrst)
        state_q == HSFS_FAULT ##1 state_q == HSFS_ON);
endmodule : hsfs_switch
